// file: logic/igp_gate_protect.sv
// gate protection and gating logic of a three-phase inverter stage
`timescale 1ns/1ps
`include "igp_consts.svh"
module igp_gate_protect
  import igp_pkg::*;
#(
  parameter int FAULT_CYCLES = `IGP_FAULT_CYCLES
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  // gate commands from controller
  input  wire igp_gates_t i_gate_cmd,
  // supply monitors and short detector
  input  wire logic       i_lowside_supply_uv,
  input  wire logic [2:0] i_highside_bias_uv,
  input  wire logic       i_short_detect,
  // gate drives
  output logic            o_gate_high,
  output igp_gates_t      o_gates,
  // open-drain fault line
  output logic            o_fault_out_n,
  output logic            o_fault_oe
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // input synchronisers
  // ****************************************
  // two-flop synchronisers
  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 11'h0;
      sync2_r <= 11'h0;
    end else begin
      sync1_r <= {i_short_detect, i_highside_bias_uv, i_lowside_supply_uv, i_gate_cmd};
      sync2_r <= sync1_r;
    end
  end

  igp_gates_t cmd;
  logic       ls_uv;
  logic [2:0] hs_uv;
  logic       sc;
  assign cmd   = igp_gates_t'(sync2_r[5:0]);
  assign ls_uv = sync2_r[6];
  assign hs_uv = sync2_r[9:7];
  assign sc    = sync2_r[10];

  // sync pipeline carries real samples only from the second edge after release
  logic [1:0] sync_vld_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_vld_r <= 2'h0;
    end else begin
      sync_vld_r <= {sync_vld_r[0], 1'b1};
    end
  end

  // previous command, for rising edges
  // held at all ones until the pipeline is filled: a command already high at release is not fresh
  igp_gates_t cmd_prev_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_prev_r <= '1;
    end else if (sync_vld_r[1]) begin
      cmd_prev_r <= cmd;
    end else begin
      cmd_prev_r <= '1;
    end
  end

  logic [2:0] hi_rise;
  logic [2:0] lo_rise;
  assign hi_rise = cmd.high & ~cmd_prev_r.high;
  assign lo_rise = cmd.low & ~cmd_prev_r.low;

  // ****************************************
  // fault pulse
  // ****************************************
  igp_flt_state_t          flt_state_r;
  logic [`IGP_FCNT_W-1:0]  flt_cnt_r;
  logic                    ls_uv_prev_r;
  logic                    sc_prev_r;
  logic                    flt_trig;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_uv_prev_r <= 1'b0;
      sc_prev_r    <= 1'b0;
    end else begin
      ls_uv_prev_r <= ls_uv;
      sc_prev_r    <= sc;
    end
  end
  // trigger on onset of low-side uv or short
  assign flt_trig = (ls_uv & ~ls_uv_prev_r) | (sc & ~sc_prev_r);

  // width set by counter only, not by fault length
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_state_r <= IGP_FLT_IDLE;
      flt_cnt_r   <= '0;
    end else begin
      case (flt_state_r)
        IGP_FLT_IDLE: begin
          if (flt_trig) begin
            flt_state_r <= IGP_FLT_PULSE;
            flt_cnt_r   <= `IGP_FCNT_W'(FAULT_CYCLES - 1);
          end
        end
        IGP_FLT_PULSE: begin
          if (flt_cnt_r == '0) begin
            flt_state_r <= IGP_FLT_IDLE;
          end else begin
            flt_cnt_r <= flt_cnt_r - 1'b1;
          end
        end
        default: begin
          flt_state_r <= IGP_FLT_IDLE;
        end
      endcase
    end
  end

  logic flt_active;
  assign flt_active = (flt_state_r == IGP_FLT_PULSE);

  // ****************************************
  // gate enables
  // ****************************************
  // enable clears on a blocking condition and sets only on a fresh rising command
  logic [2:0] hi_en_r;
  logic [2:0] lo_en_r;
  logic       lo_block;
  // low sides blocked by uv, short or fault pulse
  assign lo_block = ls_uv | sc | flt_active;

  genvar g;
  generate
    for (g = 0; g < `IGP_NPHASE; g++) begin : g_phase
      // enables start cleared and rearm on rising input
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          hi_en_r[g] <= 1'b0;
        end else if (hs_uv[g]) begin
          hi_en_r[g] <= 1'b0;
        end else if (hi_rise[g]) begin
          hi_en_r[g] <= 1'b1;
        end
      end
      // low side rearms after pulse on rising input
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          lo_en_r[g] <= 1'b0;
        end else if (lo_block) begin
          lo_en_r[g] <= 1'b0;
        end else if (lo_rise[g]) begin
          lo_en_r[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  // high side gated only by its own bias monitor
  igp_gates_t gates_nxt;
  always_comb begin
    gates_nxt.low  = cmd.low & (lo_en_r | lo_rise) & {3{~lo_block}};
    gates_nxt.high = cmd.high & (hi_en_r | hi_rise) & ~hs_uv;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_gates       <= '0;
      o_fault_out_n <= 1'b1;
    end else begin
      o_gates       <= gates_nxt;
      o_fault_out_n <= ~(flt_active | flt_trig);
    end
  end
  assign o_fault_oe  = ~o_fault_out_n;
  assign o_gate_high = |o_gates.high;

  // ****************************************
  // assertions
  // ****************************************
  // helper: length of the current low stretch on the fault line
  logic [`IGP_FCNT_W:0] flt_low_cnt_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_low_cnt_r <= '0;
    end else if (!o_fault_out_n) begin
      flt_low_cnt_r <= flt_low_cnt_r + 1'b1;
    end else begin
      flt_low_cnt_r <= '0;
    end
  end

  lowside_uv_off_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ls_uv |=> o_gates.low == 3'h0) else $error("low side on during supply uv");
  short_all_off_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    sc |=> o_gates.low == 3'h0) else $error("low side on during short");
  pulse_hold_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    flt_active |=> o_gates.low == 3'h0) else $error("low side on during fault pulse");
  hs_uv_off_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    |hs_uv |=> (o_gates.high & $past(hs_uv)) == 3'h0) else $error("high side on during bias uv");
  hs_no_fault_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (!ls_uv && !sc && !$past(ls_uv) && !$past(sc) && flt_state_r == IGP_FLT_IDLE) |=> o_fault_out_n)
    else $error("fault without low side cause");
  fault_start_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    flt_trig && !flt_active |=> !o_fault_out_n [*8]) else $error("fault pulse too short");
  pulse_width_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    $rose(o_fault_out_n) |-> flt_low_cnt_r == (`IGP_FCNT_W+1)'(FAULT_CYCLES + 1)) else $error("fault width wrong");
  rearm_edge_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    $fell(flt_active) && !lo_rise[0] && !lo_en_r[0] |=> !o_gates.low[0]) else $error("low side on without edge");
  hs_untouched_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (sc && hi_en_r == 3'h7 && hs_uv == 3'h0) |=> o_gates.high == $past(cmd.high))
    else $error("short affected high side");
  od_drive_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_fault_oe == !o_fault_out_n) else $error("fault line enable mismatch");

  short_seen_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(sc));
  pulse_end_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $fell(flt_active));
  hs_uv_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(|hs_uv));
  rearm_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(lo_en_r[0]));

endmodule

// file: logic/igp_consts.svh
// constants for the inverter gate protection block
`ifndef IGP_CONSTS_SVH
`define IGP_CONSTS_SVH
//
// Summary of operation
// - after supply release, wait next input command
// - low-side supply undervoltage forces low-side switches off
// - supply undervoltage or short gives fixed fault pulse
// - high-side bias undervoltage: that switch off, no fault
// - after undervoltage, resume on fresh rising input
// - short circuit turns all low-side switches off
// - low sides held off during fault pulse
// - after fault pulse, low side waits rising input
// - short circuit leaves high-side drives alone
// - gate inputs are active high
// - fault output is open drain, low when active
//
`define IGP_CLK_PERIOD_NS   40
`define IGP_FAULT_PULSE_US  30
`define IGP_FAULT_CYCLES    ((`IGP_FAULT_PULSE_US * 1000 + `IGP_CLK_PERIOD_NS - 1) / `IGP_CLK_PERIOD_NS)
`define IGP_FCNT_W          11
`define IGP_NPHASE          3
`endif

// file: logic/igp_pkg.sv
// types for the inverter gate protection block
package igp_pkg;
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } igp_gates_t;
  typedef enum logic [0:0] {IGP_FLT_IDLE, IGP_FLT_PULSE} igp_flt_state_t;
endpackage

// file: testbench/igp_ctrl_model.sv
// controller model driving the six gate commands
`timescale 1ns/1ps
module igp_ctrl_model
  import igp_pkg::*;
#(
  parameter int MIN_PULSE = 30
) (
  // clock
  input  wire logic i_sys_clk,
  // commands toward the block
  output igp_gates_t o_cmd
);
  initial o_cmd = '0;
  // dead time, pulse width
  // each level holds 30 cycles, the same as the 30-cycle dead time
  // switch-offs go first, so a phase never sees both sides on without a full gap
  task automatic put(input igp_gates_t v);
    @(negedge i_sys_clk);
    o_cmd = o_cmd & v;
    repeat (MIN_PULSE) @(negedge i_sys_clk);
    o_cmd = v;
    repeat (MIN_PULSE) @(negedge i_sys_clk);
  endtask
endmodule

// file: testbench/igp_gate_protect_tb_top.sv
// self-checking bench for the gate protection block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module igp_gate_protect_tb_top
  import igp_pkg::*;
;
  // ****
  // signals
  // ****
  localparam int FC = 8;
  logic       clk;
  logic       rst_n;
  logic       luv;
  logic       sdet;
  logic [2:0] buv;
  igp_gates_t cmd;
  igp_gates_t gates;
  logic       gh;
  logic       fo_n;
  logic       foe;
  int         failures;
  int         tests_run;
  int         n, bl, bh, bo;

  igp_gate_protect #(.FAULT_CYCLES(FC)) uut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_gate_cmd(cmd), .i_lowside_supply_uv(luv),
    .i_highside_bias_uv(buv), .i_short_detect(sdet), .o_gate_high(gh), .o_gates(gates),
    .o_fault_out_n(fo_n), .o_fault_oe(foe));
  igp_ctrl_model ctrl (.i_sys_clk(clk), .o_cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****
  // tasks
  // ****
  task automatic close_out();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the fault input may drop before the pulse ends, so width is seen apart from fault length
  task automatic fault_run(input logic sc, input int hold);
    n = 0;
    bl = 0;
    bh = 0;
    bo = 0;
    if (sc) sdet = 1'b1;
    else luv = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (i == hold) begin
        sdet = 1'b0;
        luv = 1'b0;
      end
      if (fo_n !== ~foe) bo++;
      if (foe === 1'b1) begin
        n++;
        if (gates.low !== 3'h0) bl++;
        if (gates.high !== cmd.high) bh++;
      end
    end
  endtask

  // drop the given bits, then raise them again: the fresh edge a blocked gate waits for
  task automatic retrigger(input igp_gates_t v, input igp_gates_t bits);
    ctrl.put(v & ~bits);
    ctrl.put(v);
  endtask

  task automatic t_basic();
    igp_gates_t v;
    for (int p = 0; p < 3; p++) begin
      v = '0;
      v.low[p] = 1'b1;
      ctrl.put(v);
      `CHK("gates", v, gates)
      `CHK("gh", 1'h0, gh)
      v = '0;
      v.high[p] = 1'b1;
      ctrl.put(v);
      `CHK("gates", v, gates)
      `CHK("gh", 1'h1, gh)
    end
    v = '0;
    ctrl.put(v);
    `CHK("gates", 6'h00, gates)
  endtask

  task automatic t_reset();
    igp_gates_t v;
    v = 6'h07;
    ctrl.put(v);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("gates", 6'h00, gates)
    `CHK("fault", 1'h1, fo_n)
    retrigger(v, 6'h07);
    `CHK("gates", 6'h07, gates)
  endtask

  task automatic t_luv();
    igp_gates_t v;
    v = 6'h31;
    ctrl.put(v);
    fault_run(1'b0, 30);
    `CHK("width", FC + 1, n)
    `CHK("low", 0, bl)
    `CHK("oe", 0, bo)
    `CHK("low", 3'h0, gates.low)
    retrigger(v, 6'h01);
    `CHK("low", 3'h1, gates.low)
  endtask

  task automatic t_short();
    igp_gates_t v;
    // all three high sides are raised once so every high enable is armed during the short
    v = 6'h38;
    ctrl.put(v);
    v = 6'h31;
    ctrl.put(v);
    fault_run(1'b1, 2);
    `CHK("width", FC + 1, n)
    `CHK("low", 0, bl)
    `CHK("high", 0, bh)
    `CHK("oe", 0, bo)
    `CHK("gates", 6'h30, gates)
    retrigger(v, 6'h01);
    `CHK("gates", 6'h31, gates)
  endtask

  task automatic t_bias();
    logic [2:0] m;
    igp_gates_t v;
    v = 6'h38;
    for (int p = 0; p < 3; p++) begin
      m = 3'h1 << p;
      ctrl.put(v);
      buv = m;
      repeat (6) @(negedge clk);
      `CHK("high", ~m, gates.high)
      `CHK("fault", 1'h0, foe)
      buv = 3'h0;
      repeat (6) @(negedge clk);
      `CHK("high", ~m, gates.high)
      retrigger(v, 6'h38);
      `CHK("high", 3'h7, gates.high)
    end
  endtask

  // ****
  // sequence
  // ****
  initial begin
    luv = 1'b0;
    sdet = 1'b0;
    buv = 3'h0;
    rst_n = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_basic();
    t_reset();
    t_luv();
    t_short();
    t_bias();
    close_out();
  end

  // run is about 1700 cycles; this allows nearly six times that
  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule
